/* core/aic_controller.sv */
`timescale 1ns/100ps
`default_nettype none
`include "aic_regs.svh"

module aic_controller
	import aic_pkg::*;
#(
	parameter int P_FIFO_DEPTH = `AIC_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_rstn,
	// Input sampling control
	input  wire logic         i_run,
	input  wire logic [15:0]  i_rate_code,
	input  wire logic [2:0]   i_chan_count,
	input  wire logic [3:0]   i_buf_size,
	input  wire logic         i_buf_clear,
	input  wire logic         i_offset_binary,
	// Input switches
	input  wire logic [1:0]   i_in_source,
	input  wire logic         i_differential,
	output var  logic [1:0]   o_in_source,
	output var  logic         o_in_diff,
	// Converter pins
	input  wire logic [127:0] i_adc_data,
	input  wire logic         i_adc_busy,
	output var  logic         o_adc_convert,
	// Sample buffer read
	input  wire logic         i_rd_req,
	output var  logic [31:0]  o_rd_data,
	output var  logic         o_rd_valid,
	output var  logic         o_buf_empty,
	output var  logic         o_buf_full,
	output var  logic [15:0]  o_buf_level,
	// Output channels
	input  wire logic [127:0] i_out_word,
	input  wire logic [3:0]   i_out_write,
	input  wire logic         i_strobe_mode,
	input  wire logic         i_sw_strobe,
	input  wire logic         i_ext_strobe,
	input  wire logic         i_out_isolate,
	output var  logic         o_out_connect,
	output var  logic         o_dac_sclk,
	output var  logic         o_dac_sdata,
	output var  logic [3:0]   o_dac_cs_n,
	output var  logic [3:0]   o_dac_ldac_n,
	// Calibration
	input  wire logic         i_cal_start,
	output var  logic         o_cal_busy,
	output var  logic         o_trim_we,
	output var  logic [4:0]   o_trim_addr,
	output var  logic [11:0]  o_trim_data,
	// Nonvolatile trim store
	input  wire logic         i_nv_done,
	input  wire logic [11:0]  i_nv_data,
	output var  logic         o_nv_we,
	output var  logic         o_nv_rd,
	output var  logic [4:0]   o_nv_addr,
	output var  logic [11:0]  o_nv_data
);

	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	logic [127:0] adc_meta;
	logic [127:0] adc_sync;
	logic         busy_meta;
	logic         busy_sync;
	logic         stb_meta;
	logic         stb_sync;
	logic         stb_last;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			adc_meta  <= '0;
			adc_sync  <= '0;
			busy_meta <= 1'b0;
			busy_sync <= 1'b0;
			stb_meta  <= 1'b0;
			stb_sync  <= 1'b0;
			stb_last  <= 1'b0;
		end else begin
			adc_meta  <= i_adc_data;
			adc_sync  <= adc_meta;
			busy_meta <= i_adc_busy;
			busy_sync <= busy_meta;
			stb_meta  <= i_ext_strobe;
			stb_sync  <= stb_meta;
			stb_last  <= stb_sync;
		end
	end

	logic [15:0] adc_word [`AIC_N_IN];

	for (genvar g = 0; g < `AIC_N_IN; g++) begin : g_adc
		assign adc_word[g] = adc_sync[g*`AIC_WORD_BITS +: `AIC_WORD_BITS];
	end

	//------------------------------------------------------------
	// Sample buffer
	//------------------------------------------------------------
	aic_fifo_if #(.WIDTH(`AIC_WORD_BITS), .DEPTH(P_FIFO_DEPTH)) fq ();

	aic_fifo #(
		.WIDTH (`AIC_WORD_BITS),
		.DEPTH (P_FIFO_DEPTH)
	) u_fifo (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.f       (fq.store)
	);

	aic_state_t  state;
	aic_state_t  next_state;
	logic [2:0]  chan;
	logic [4:0]  trim_idx;
	logic [3:0]  bit_idx;
	logic [11:0] trim_val;
	logic [3:0]  settle;
	logic [15:0] rate_cnt;
	logic        sample_due;
	logic        cal_req;
	logic        reload_req;

	// Virtual depth is 2**code samples, capped by the physical store
	wire [16:0] vsize    = 17'h1 << i_buf_size;
	wire        room     = 17'(fq.level) < vsize;
	wire        wr_fire  = fq.wr_valid & fq.wr_ready & room;
	wire [15:0] rd_word  = fq.rd_data;
	wire [15:0] rd_twos  = rd_word ^ `AIC_SIGN_FLIP;
	wire [31:0] rd_fmt   = i_offset_binary ? {16'h0, rd_word}
		: {{16{rd_twos[15]}}, rd_twos};

	assign fq.wr_valid = (state == S_STORE) & room;
	assign fq.wr_data  = adc_word[chan];
	assign fq.rd_ready = i_rd_req;
	assign fq.clear    = i_buf_clear;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rd_data   <= '0;
			o_rd_valid  <= 1'b0;
			o_buf_empty <= 1'b1;
			o_buf_full  <= 1'b0;
			o_buf_level <= '0;
		end else begin
			o_rd_valid  <= fq.rd_valid & i_rd_req;
			if (fq.rd_valid & i_rd_req)
				o_rd_data <= rd_fmt;
			o_buf_empty <= fq.level == '0;
			o_buf_full  <= !(room & fq.wr_ready);
			o_buf_level <= 16'(fq.level);
		end
	end

	//------------------------------------------------------------
	// Sample rate
	//------------------------------------------------------------
	// One event every rate_code + 1 clocks while running
	wire rate_hit = i_run & (rate_cnt == i_rate_code);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			rate_cnt <= '0;
		else if (!i_run || rate_hit)
			rate_cnt <= '0;
		else
			rate_cnt <= rate_cnt + 16'h1;
	end

	//------------------------------------------------------------
	// Sequencer: sampling, calibration and trim reload
	//------------------------------------------------------------
	wire        in_phase   = trim_idx < `AIC_TRIM_OUT_BASE;
	wire [2:0]  meas_ch    = in_phase ? trim_idx[3:1] : 3'h0;
	wire [15:0] meas       = adc_word[meas_ch];
	wire [15:0] target     = trim_idx[0] ? `AIC_GAIN_TARGET : `AIC_OFFSET_TARGET;
	wire [11:0] bit_mask   = 12'h1 << bit_idx;
	wire [11:0] trim_try   = trim_val | bit_mask;
	wire        overshoot  = meas > target;
	wire [11:0] trim_keep  = (state == S_JUDGE) & overshoot ? trim_val & ~bit_mask : trim_val;
	wire        trim_last  = trim_idx == `AIC_TRIM_LAST;
	wire        settled    = (settle == 4'h0) & !busy_sync;
	wire        store_last = chan == i_chan_count;
	wire        cal_take   = (state == S_IDLE) & cal_req;
	wire        load_take  = (state == S_IDLE) & !cal_req & reload_req;
	wire        samp_take  = (state == S_IDLE) & !cal_req & !reload_req & sample_due;

	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: begin
				if (cal_req)
					next_state = S_TRIM;
				else if (reload_req)
					next_state = S_RDNV;
				else if (sample_due)
					next_state = S_CONV;
			end
			S_CONV:  next_state = S_WAIT;
			S_WAIT: begin
				if (settled)
					next_state = o_cal_busy ? S_JUDGE : S_STORE;
			end
			S_STORE: begin
				if (wr_fire && store_last)
					next_state = S_IDLE;
			end
			S_TRIM:  next_state = S_CONV;
			S_JUDGE: next_state = (bit_idx == 4'h0) ? S_SAVE : S_TRIM;
			S_SAVE: begin
				if (i_nv_done)
					next_state = trim_last ? S_RDNV : S_TRIM;
			end
			S_RDNV: begin
				if (i_nv_done)
					next_state = S_LOAD;
			end
			S_LOAD:  next_state = trim_last ? S_IDLE : S_RDNV;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state      <= S_IDLE;
			cal_req    <= 1'b0;
			reload_req <= 1'b1;
			sample_due <= 1'b0;
			settle     <= '0;
		end else begin
			state      <= next_state;
			cal_req    <= i_cal_start | (cal_req & !cal_take);
			reload_req <= reload_req & !load_take;
			sample_due <= rate_hit | (sample_due & !samp_take);
			if (state == S_CONV)
				settle <= `AIC_SETTLE_CYC;
			else if (settle != 4'h0)
				settle <= settle - 4'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			chan       <= '0;
			trim_idx   <= '0;
			bit_idx    <= `AIC_TRIM_MSB;
			trim_val   <= '0;
			o_cal_busy <= 1'b0;
		end else begin
			if (samp_take)
				chan <= 3'h0;
			else if ((state == S_STORE) && wr_fire)
				chan <= chan + 3'h1;
			if (cal_take || load_take) begin
				o_cal_busy <= cal_take;
				trim_idx   <= '0;
				bit_idx    <= `AIC_TRIM_MSB;
				trim_val   <= '0;
			end
			unique case (state)
				S_TRIM:  trim_val <= trim_try;
				S_JUDGE: begin
					trim_val <= trim_keep;
					bit_idx  <= bit_idx - 4'h1;
				end
				S_SAVE: begin
					if (i_nv_done) begin
						bit_idx  <= `AIC_TRIM_MSB;
						trim_val <= '0;
						trim_idx <= trim_last ? 5'h0 : trim_idx + 5'h1;
					end
				end
				S_RDNV: begin
					if (i_nv_done)
						trim_val <= i_nv_data;
				end
				S_LOAD: begin
					trim_idx <= trim_last ? 5'h0 : trim_idx + 5'h1;
					if (trim_last)
						o_cal_busy <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_adc_convert <= 1'b0;
			o_trim_we     <= 1'b0;
			o_trim_addr   <= '0;
			o_trim_data   <= '0;
			o_nv_we       <= 1'b0;
			o_nv_rd       <= 1'b0;
			o_nv_addr     <= '0;
			o_nv_data     <= '0;
		end else begin
			o_adc_convert <= state == S_CONV;
			o_trim_we     <= (state == S_TRIM) | (state == S_LOAD);
			o_trim_addr   <= trim_idx;
			o_trim_data   <= (state == S_TRIM) ? trim_try : trim_val;
			o_nv_we       <= (next_state == S_SAVE) & (state != S_SAVE);
			o_nv_rd       <= (next_state == S_RDNV) & (state != S_RDNV);
			o_nv_addr     <= (next_state == S_RDNV) ? ((state == S_LOAD) ?
				trim_idx + 5'h1 : 5'h0) : trim_idx;
			o_nv_data     <= trim_keep;
		end
	end

	//------------------------------------------------------------
	// Analog switches and isolation
	//------------------------------------------------------------
	wire [1:0] cal_src = in_phase ? `AIC_SRC_REF : `AIC_SRC_LOOP;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_in_source   <= `AIC_SRC_NORMAL;
			o_in_diff     <= 1'b0;
			o_out_connect <= 1'b0;
		end else begin
			o_in_source   <= o_cal_busy ? cal_src : i_in_source;
			o_in_diff     <= o_cal_busy | i_differential;
			o_out_connect <= !(i_out_isolate | o_cal_busy);
		end
	end

	//------------------------------------------------------------
	// Output DAC serial loader
	//------------------------------------------------------------
	aic_shift_t  sh_state;
	logic [3:0]  pending;
	logic [1:0]  sh_ch;
	logic [15:0] sh_reg;
	logic [3:0]  sh_bits;

	wire [1:0]  pick      = pending[0] ? 2'h0 : pending[1] ? 2'h1 : pending[2] ? 2'h2 : 2'h3;
	wire [15:0] pick_raw  = i_out_word[{pick, 5'h0} +: 16];
	wire [15:0] pick_code = i_offset_binary ? pick_raw : pick_raw ^ `AIC_SIGN_FLIP;
	wire        sh_start  = (sh_state == SH_IDLE) & (pending != 4'h0);
	wire        ext_rise  = stb_sync & !stb_last;
	wire        strobe    = i_strobe_mode & (i_sw_strobe | ext_rise);
	wire        auto_xfer = (sh_state == SH_XFER) & !i_strobe_mode;
	wire [3:0]  start_oh  = sh_start ? (4'h1 << pick) : 4'h0;
	wire [3:0]  xfer_oh   = auto_xfer ? (4'h1 << sh_ch) : 4'h0;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pending      <= '0;
			o_dac_ldac_n <= 4'hf;
		end else begin
			pending      <= i_out_write | (pending & ~start_oh);
			o_dac_ldac_n <= ~({4{strobe}} | xfer_oh);
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sh_state    <= SH_IDLE;
			sh_ch       <= '0;
			sh_reg      <= '0;
			sh_bits     <= '0;
			o_dac_sclk  <= 1'b0;
			o_dac_sdata <= 1'b0;
			o_dac_cs_n  <= 4'hf;
		end else begin
			unique case (sh_state)
				SH_IDLE: begin
					if (sh_start) begin
						sh_ch      <= pick;
						sh_reg     <= pick_code;
						sh_bits    <= 4'hf;
						o_dac_cs_n <= ~(4'h1 << pick);
						sh_state   <= SH_LOW;
					end
				end
				SH_LOW: begin
					o_dac_sclk  <= 1'b0;
					o_dac_sdata <= sh_reg[15];
					sh_state    <= SH_HIGH;
				end
				SH_HIGH: begin
					o_dac_sclk <= 1'b1;
					sh_reg     <= {sh_reg[14:0], 1'b0};
					sh_bits    <= sh_bits - 4'h1;
					sh_state   <= (sh_bits == 4'h0) ? SH_XFER : SH_LOW;
				end
				SH_XFER: begin
					o_dac_sclk <= 1'b0;
					o_dac_cs_n <= 4'hf;
					sh_state   <= SH_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

/* core/aic_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module aic_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic  i_clock,
	input  wire logic  i_rstn,
	// Data path
	aic_fifo_if.store  f
);
	// DEPTH must be a power of two so the pointers wrap by themselves
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;

	wire push = f.wr_valid & f.wr_ready;
	wire pop  = f.rd_valid & f.rd_ready;

	assign f.wr_ready = count != CW'(DEPTH);
	assign f.rd_valid = count != '0;
	assign f.rd_data  = mem[rd_ptr];
	assign f.level    = count;

	always_ff @(posedge i_clock) begin
		if (push)
			mem[wr_ptr] <= f.wr_data;
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (f.clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count  <= count + CW'(push) - CW'(pop);
		end
	end
endmodule

`default_nettype wire

/* core/aic_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface aic_fifo_if #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
);
	localparam int CW = $clog2(DEPTH + 1);

	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;
	logic             clear;
	logic [CW-1:0]    level;

	modport user (output wr_valid, wr_data, rd_ready, clear,
		input wr_ready, rd_valid, rd_data, level);
	modport store (input wr_valid, wr_data, rd_ready, clear,
		output wr_ready, rd_valid, rd_data, level);
endinterface

`default_nettype wire

/* core/aic_pkg.sv */
package aic_pkg;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_CONV  = 4'h1,
		S_WAIT  = 4'h3,
		S_STORE = 4'h2,
		S_TRIM  = 4'h6,
		S_JUDGE = 4'h7,
		S_SAVE  = 4'h5,
		S_RDNV  = 4'h4,
		S_LOAD  = 4'hc
	} aic_state_t;

	typedef enum logic [1:0] {
		SH_IDLE = 2'h0,
		SH_LOW  = 2'h1,
		SH_HIGH = 2'h3,
		SH_XFER = 2'h2
	} aic_shift_t;

endpackage

/* core/aic_regs.svh */
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

// Overview of operation
// - Convert all inputs at one instant, then push the words into the FIFO in turn.
// - A 16-bit rate code from the host sets the continuous sampling rate.
// - A 3-bit count code selects one to eight channels stored per sampling event.
// - Physical input buffer, virtual depth from one sample upward via a 4-bit code.
// - Each output word is fetched from its data register and shifted into its DAC.
// - With strobing on, DAC transfer happens only on software or external strobe.
// - With strobing off, the transfer is issued right after the serial shift ends.
// - Outputs isolate on request or during calibration, all four together.
// - Input switches select connector, internal reference, or output loopback.
// - Software selects single-ended or differential input configuration.
// - Each trim DAC is found by a 12-bit successive approximation from zero.
// - Final trim values go to nonvolatile memory and are reloaded from there.
// - Inputs are calibrated against the reference first, then outputs via an input.
// - Every channel has offset and gain 12-bit trim DACs, 24 in all.
// - A calibration request is latched at any moment and taken once the sequencer is idle.
// - Offset binary when the coding bit is high, two's complement when low.
// - Two's complement reads sign-extend to bit 31; output bits 16 to 31 ignored.

`define AIC_N_IN          8
`define AIC_N_OUT         4
`define AIC_WORD_BITS     16
`define AIC_TRIM_BITS     12
`define AIC_FIFO_DEPTH    16
`define AIC_TRIM_MSB      4'hb
`define AIC_TRIM_LAST     5'h17
`define AIC_TRIM_OUT_BASE 5'h10
`define AIC_SRC_NORMAL    2'h0
`define AIC_SRC_REF       2'h1
`define AIC_SRC_LOOP      2'h2
`define AIC_SIGN_FLIP     16'h8000
`define AIC_OFFSET_TARGET 16'h8000
`define AIC_GAIN_TARGET   16'hffbe
`define AIC_SETTLE_CYC    4'h4

`endif

/* sim/aic_controller_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module aic_controller_bench;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         run, clr, ob, diff, rdq, smode, sws, exts, iso, cal;
	logic         busy, nvd, odiff, conv, rdv, emp, full, conn, sclk, sda;
	logic         cbusy, twe, nwe, nrd, sclk_q, csl_q, rl;
	logic [1:0]   src, osrc;
	logic [2:0]   cc;
	logic [3:0]   bsz, owr, cs_n, ld_n;
	logic [4:0]   ta, na;
	logic [11:0]  td, nd, nvq;
	logic [15:0]  rate, lvl, sh;
	logic [31:0]  rdat;
	logic [127:0] ow, adc;
	logic [31:0]  q_rd[$];
	logic [15:0]  q_dac[$];
	int           err_count = 0;
	int           total_checks = 0;
	int           gap, cgap, nv_cnt, tr_cnt;

	always #2.5 clk = ~clk;

	aic_controller dut (
		.i_clock(clk), .i_rstn(rst_n), .i_run(run), .i_rate_code(rate),
		.i_chan_count(cc), .i_buf_size(bsz), .i_buf_clear(clr), .i_offset_binary(ob),
		.i_in_source(src), .i_differential(diff), .o_in_source(osrc), .o_in_diff(odiff),
		.i_adc_data(adc), .i_adc_busy(busy), .o_adc_convert(conv), .i_rd_req(rdq),
		.o_rd_data(rdat), .o_rd_valid(rdv), .o_buf_empty(emp), .o_buf_full(full),
		.o_buf_level(lvl), .i_out_word(ow), .i_out_write(owr), .i_strobe_mode(smode),
		.i_sw_strobe(sws), .i_ext_strobe(exts), .i_out_isolate(iso), .o_out_connect(conn),
		.o_dac_sclk(sclk), .o_dac_sdata(sda), .o_dac_cs_n(cs_n), .o_dac_ldac_n(ld_n),
		.i_cal_start(cal), .o_cal_busy(cbusy), .o_trim_we(twe), .o_trim_addr(ta),
		.o_trim_data(td), .i_nv_done(nvd), .i_nv_data(nvq), .o_nv_we(nwe),
		.o_nv_rd(nrd), .o_nv_addr(na), .o_nv_data(nd)
	);

	aic_far far (
		.i_clock(clk), .i_rstn(rst_n), .i_convert(conv), .i_cal(cbusy),
		.i_trim_we(twe), .i_trim(td), .o_adc(adc), .o_busy(busy), .i_we(nwe),
		.i_rd(nrd), .i_addr(na), .i_data(nd), .o_done(nvd), .o_data(nvq)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic tmo(input int n);
		if (n == 0) begin
			err_count++;
			wrap_up();
		end
	endtask

	// ----------------------------------------
	// Result monitor
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst_n) begin
			sclk_q <= sclk;
			csl_q <= ~&cs_n;
			cgap <= conv ? 1 : cgap + 1;
			if (conv)
				gap <= cgap;
			if (sclk && !sclk_q)
				sh <= {sh[14:0], sda};
			if (csl_q && &cs_n)
				check(32'(sh), 32'(q_dac.pop_front()));
			if (rdv)
				check(rdat, q_rd.pop_front());
			if (nrd) begin
				rl <= 1'b1;
				check(32'(na), 32'((tr_cnt + int'(twe)) % 24));
			end
			if (nwe) begin
				rl <= 1'b0;
				nv_cnt <= nv_cnt + 1;
				check(32'(nd), na[0] ? 32'hffb : 32'h800);
				check(32'(na), nv_cnt);
			end
			if (twe && rl) begin
				tr_cnt <= tr_cnt + 1;
				check(32'(td), 32'(far.mem[ta]));
			end
		end
	end

	initial begin
		int n, k, d, w;
		logic [31:0] x;
		logic [15:0] v;
		{run, clr, ob, diff, rdq, smode, sws, exts, iso, cal} = '0;
		{rate, cc, bsz, src, owr, ow, sclk_q, csl_q, rl, sh} = '0;
		{gap, cgap, nv_cnt, tr_cnt} = '0;
		n = $urandom(10);
		repeat (20) @(posedge clk);
		check(32'(emp), 32'h1);
		#1 rst_n = 1'b1;
		for (n = 5000; n > 0 && (tr_cnt < 24 || cbusy); n--)
			tick();
		tmo(n);
		check(tr_cnt, 24);
		$display("trim reload test done");
		for (k = 0; k < 8; k++) begin
			{clr, run} = 2'h2;
			repeat (40) tick();
			clr = 1'b0;
			cc = k[2:0];
			bsz = 4'(k % 5);
			d = 1 << bsz;
			ob = 1'($urandom);
			rate = 16'(40 + $urandom % 40);
			for (w = 0; w < 8; w++)
				far.words[16*w +: 16] = 16'($urandom);
			run = 1'b1;
			if (2 * (k + 1) <= d) begin
				for (n = 2000; n > 0 && lvl < 16'(2 * (k + 1)); n--)
					tick();
				tmo(n);
				check(gap, 32'(rate) + 1);
			end
			for (n = 2000; n > 0 && !full; n--)
				tick();
			tmo(n);
			repeat (100) tick();
			run = 1'b0;
			check(32'(lvl), d);
			check(32'(full), 32'h1);
			for (w = 0; w < d; w++) begin
				v = far.words[16*(w % (k + 1)) +: 16];
				x = ob ? {16'h0, v} : {{16{~v[15]}}, v ^ 16'h8000};
				q_rd.push_back(x);
				for (n = 200; n > 0 && emp; n--)
					tick();
				tmo(n);
				rdq = 1'b1;
				tick();
				rdq = 1'b0;
				repeat (1 + $urandom % 3) tick();
			end
			repeat (3) tick();
		end
		$display("sampling and buffer test done");
		for (k = 0; k < 8; k++) begin
			smode = k[2];
			w = k % 4;
			x = $urandom;
			ow[32*w +: 32] = x;
			q_dac.push_back(ob ? x[15:0] : x[15:0] ^ 16'h8000);
			owr = 4'h1 << w;
			tick();
			owr = 4'h0;
			for (n = 50; n > 0 && &cs_n; n--)
				tick();
			tmo(n);
			for (n = 200; n > 0 && !(&cs_n); n--)
				tick();
			tmo(n);
			if (smode) begin
				repeat (4) tick();
				sws = k[0];
				exts = !k[0];
				tick();
				sws = 1'b0;
				for (n = 8; n > 0 && &ld_n; n--)
					tick();
				check(32'(ld_n), 32'h0);
				exts = 1'b0;
			end
		end
		$display("output dac test done");
		for (k = 0; k < 3; k++) begin
			src = k[1:0];
			diff = k[0];
			iso = k[0];
			repeat (4) tick();
			check(32'(osrc), k);
			check(32'(odiff), 32'(diff));
			check(32'(conn), 32'(!iso));
		end
		$display("switch test done");
		{clr, cc, bsz, src, diff, iso} = {1'b1, 3'h7, 4'h4, 4'h0};
		repeat (40) tick();
		{clr, run} = 2'h1;
		repeat (25) tick();
		{cal, rl} = 2'h2;
		tick();
		{cal, run} = 2'h0;
		for (n = 300; n > 0 && !cbusy; n--)
			tick();
		tmo(n);
		for (n = 40000; n > 0 && cbusy; n--)
			tick();
		tmo(n);
		repeat (4) tick();
		check(nv_cnt, 24);
		check(tr_cnt, 48);
		check(32'(conn), 32'h1);
		$display("calibration test done");
		wrap_up();
	end
endmodule

`default_nettype wire

/* sim/aic_controller_properties.sv */
`timescale 1ns/100ps
`default_nettype none

module aic_controller_properties (
	// Clock and reset
	input wire logic       i_clock,
	input wire logic       i_rstn,
	// Buffer and converters
	input wire logic       i_rd_req,
	input wire logic       o_buf_empty,
	input wire logic       o_rd_valid,
	input wire logic       o_adc_convert,
	// Output side
	input wire logic       i_strobe_mode,
	input wire logic       i_sw_strobe,
	input wire logic       i_out_isolate,
	input wire logic [3:0] o_dac_cs_n,
	input wire logic [3:0] o_dac_ldac_n,
	input wire logic       o_dac_sclk,
	input wire logic       o_out_connect,
	// Calibration
	input wire logic       o_cal_busy,
	input wire logic       o_in_diff,
	input wire logic [1:0] o_in_source,
	input wire logic       o_trim_we,
	input wire logic [4:0] o_trim_addr
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	// ----------------------------------------
	// Serial clock rises while a DAC is selected
	// ----------------------------------------
	logic [4:0] nbits;
	logic       sclk_q;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			nbits <= 5'h0;
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= o_dac_sclk;
			if (&o_dac_cs_n)
				nbits <= 5'h0;
			else if (o_dac_sclk && !sclk_q)
				nbits <= nbits + 5'h1;
		end
	end

	property p_conv;
		o_adc_convert |=> !o_adc_convert;
	endproperty
	a_conv: assert property (p_conv) else $error("convert pulse too long");
	property p_read;
		i_rd_req && !o_buf_empty |=> o_rd_valid;
	endproperty
	a_read: assert property (p_read) else $error("read not answered");
	property p_bits;
		$rose(&o_dac_cs_n) |-> nbits == 5'h10;
	endproperty
	a_bits: assert property (p_bits) else $error("serial word not 16 bits");
	property p_auto;
		!i_strobe_mode && $rose(&o_dac_cs_n) |-> o_dac_ldac_n == $past(o_dac_cs_n);
	endproperty
	a_auto: assert property (p_auto) else $error("no transfer after shift");
	property p_strobe;
		i_strobe_mode && !i_sw_strobe && $rose(&o_dac_cs_n) |=> &o_dac_ldac_n;
	endproperty
	a_strobe: assert property (p_strobe) else $error("transfer without strobe");
	property p_isolate;
		(o_cal_busy || i_out_isolate) [*2] |-> !o_out_connect;
	endproperty
	a_isolate: assert property (p_isolate) else $error("outputs not isolated");
	property p_cal_sw;
		o_cal_busy [*2] |-> o_in_diff && o_in_source != 2'h0;
	endproperty
	a_cal_sw: assert property (p_cal_sw) else $error("switches wrong in calibration");
	property p_trim;
		o_trim_we |-> o_trim_addr <= 5'h17;
	endproperty
	a_trim: assert property (p_trim) else $error("trim address out of range");
endmodule

bind aic_controller aic_controller_properties u_props (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_rd_req(i_rd_req), .o_buf_empty(o_buf_empty),
	.o_rd_valid(o_rd_valid), .o_adc_convert(o_adc_convert), .i_strobe_mode(i_strobe_mode),
	.i_sw_strobe(i_sw_strobe), .i_out_isolate(i_out_isolate), .o_dac_cs_n(o_dac_cs_n),
	.o_dac_ldac_n(o_dac_ldac_n), .o_dac_sclk(o_dac_sclk), .o_out_connect(o_out_connect),
	.o_cal_busy(o_cal_busy), .o_in_diff(o_in_diff), .o_in_source(o_in_source),
	.o_trim_we(o_trim_we), .o_trim_addr(o_trim_addr)
);

`default_nettype wire

/* sim/aic_far.sv */
`timescale 1ns/100ps
`default_nettype none

module aic_far (
	// Clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_rstn,
	// Converter pins
	input  wire logic         i_convert,
	input  wire logic         i_cal,
	input  wire logic         i_trim_we,
	input  wire logic [11:0]  i_trim,
	output var  logic [127:0] o_adc,
	output var  logic         o_busy,
	// Trim store pins
	input  wire logic         i_we,
	input  wire logic         i_rd,
	input  wire logic [4:0]   i_addr,
	input  wire logic [11:0]  i_data,
	output var  logic         o_done,
	output var  logic [11:0]  o_data
);
	logic [127:0] words;
	logic [11:0]  mem [24];
	logic [11:0]  trim;
	logic [3:0]   bcnt;
	logic [2:0]   ncnt;
	logic [4:0]   addr;
	logic         rdop;

	initial begin
		words = '0;
		for (int i = 0; i < 24; i++)
			mem[i] = 12'(i * 173);
	end

	// In calibration every input reads back the trim under test
	always @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			{o_busy, bcnt, ncnt, o_done, trim, rdop} <= '0;
			o_adc <= '0;
			o_data <= '0;
		end else begin
			if (i_trim_we)
				trim <= i_trim;
			if (i_convert) begin
				bcnt <= 4'h6;
				o_busy <= 1'b1;
				o_adc <= ~o_adc;
			end else if (bcnt != 4'h0) begin
				bcnt <= bcnt - 4'h1;
				o_busy <= (bcnt != 4'h1);
				if (bcnt == 4'h2)
					o_adc <= i_cal ? {8{trim, 4'h0}} : words;
			end
			if (i_we || i_rd) begin
				ncnt <= 3'h3;
				addr <= i_addr;
				rdop <= i_rd;
				if (i_we)
					mem[i_addr] <= i_data;
			end else if (ncnt != 3'h0)
				ncnt <= ncnt - 3'h1;
			o_done <= (ncnt == 3'h1);
			o_data <= (ncnt == 3'h1 && rdop) ? mem[addr] : ~o_data;
		end
	end
endmodule

`default_nettype wire
